// *** bit_slot_engine.sv ***
// time slot generator for the open-drain line, one microsecond base
`timescale 1ns/100ps
`include "swm_defines.svh"
module bit_slot_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic dq_in,
	slot_if.engine   sl,
	output logic     dq_oe
);
	logic [4:0] tick_cnt_q;
	logic [9:0] us_q;
	logic [9:0] us_nx;
	logic       busy_q;
	logic       kind_rst_q;
	logic       wbit_q;
	logic       seen_q;
	logic       tick;
	logic       win;

	assign tick = (tick_cnt_q == `TAU_CYC - 5'h1);
	// judge the count as it stands after this tick, else each low
	// time and slot length runs one microsecond long
	assign us_nx = us_q + 10'h1;
	assign win  = (us_q >= `T_RSTL_US + `T_PDH_MIN_US) &&
		(us_q <= `T_RSTL_US + `T_PDH_MAX_US + `T_PDS_US);

	always_ff @(posedge clk) begin
		if (rst || !busy_q || tick) begin
			tick_cnt_q <= 5'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 5'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q      <= 1'b0;
			kind_rst_q  <= 1'b0;
			wbit_q      <= 1'b1;
			seen_q      <= 1'b0;
			us_q        <= 10'h0;
			dq_oe       <= 1'b0;
			sl.done     <= 1'b0;
			sl.rbit     <= 1'b1;
			sl.presence <= 1'b0;
		end else begin
			sl.done <= 1'b0;
			if (!busy_q && sl.req) begin
				busy_q     <= 1'b1;
				kind_rst_q <= sl.is_reset;
				wbit_q     <= sl.wbit;
				seen_q     <= 1'b0;
				us_q       <= 10'h0;
				dq_oe      <= 1'b1;
			end else if (busy_q && tick) begin
				us_q <= us_nx;
				if (kind_rst_q) begin
					if (us_nx == `T_RSTL_US) begin
						dq_oe <= 1'b0;
					end
					// presence may start late; watch the whole window
					if (win && !dq_in) begin
						seen_q <= 1'b1;
					end
					if (us_nx == `T_RSTL_US + `T_RSTH_US) begin
						busy_q      <= 1'b0;
						sl.done     <= 1'b1;
						sl.presence <= seen_q;
					end
				end else begin
					if (us_nx == (wbit_q ? `T_LOW1_US : `T_LOW0_US)) begin
						dq_oe <= 1'b0;
					end
					if (us_nx == `T_RDV_US) begin
						sl.rbit <= dq_in;
					end
					if (us_nx == `T_SLOT_US + `T_REC_US) begin
						busy_q  <= 1'b0;
						sl.done <= 1'b1;
					end
				end
			end
		end
	end
endmodule : bit_slot_engine

// *** byte_buffer.sv ***
// two entry byte buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "swm_defines.svh"
module byte_buffer #(
	parameter int WIDTH = `BYTE_W,
	parameter int DEPTH = `BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	byte_stream_if.snk  in_s,
	byte_stream_if.src  out_s
);
	logic [WIDTH-1:0]         mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_ptr_q;
	logic [$clog2(DEPTH)-1:0] rd_ptr_q;
	logic [$clog2(DEPTH):0]   count_q;
	logic                     push;
	logic                     pop;

	assign in_s.ready  = (count_q != ($clog2(DEPTH)+1)'(DEPTH));
	assign out_s.valid = (count_q != '0);
	assign out_s.data  = mem[rd_ptr_q];
	assign push = in_s.valid & in_s.ready;
	assign pop  = out_s.valid & out_s.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_s.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + {{$clog2(DEPTH){1'b0}}, push}
				- {{$clog2(DEPTH){1'b0}}, pop};
		end
	end
endmodule : byte_buffer

// *** single_wire_master_read_search.sv ***
// single wire bus master: host port, byte receive path and search
`timescale 1ns/100ps
`include "swm_defines.svh"
module single_wire_master_read_search
	import swm_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	input  wire logic [2:0] ADDR,
	input  wire logic       EN_N,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic [7:0] DATA_IN,
	output logic      [7:0] DATA_OUT,
	output logic            DATA_OE,
	input  wire logic       DQ_IN,
	output logic            DQ_OUT,
	output logic            DQ_OE
);
	byte_stream_if tx_in ();
	byte_stream_if tx_out ();
	slot_if        slot ();

	logic [14:0] sync1_q;
	logic [14:0] sync2_q;
	logic [2:0]  addr_s;
	logic        en_n_s;
	logic        rd_n_s;
	logic        wr_n_s;
	byte_t       din_s;
	logic        dq_s;
	logic        rd_n_prev_q;
	logic        wr_n_prev_q;
	logic        en_n_prev_q;
	logic        wr_evt;
	logic        rd_end;
	logic        rd_active;

	state_t      state_q;
	byte_t       tx_sh_q;
	byte_t       rx_sh_q;
	byte_t       rx_buf_q;
	logic [2:0]  bit_cnt_q;
	logic [1:0]  pos_cnt_q;
	logic        b0_q;
	logic        b2_q;
	logic        disc_q;
	logic        err_q;
	logic        cmd_rst_q;
	logic        cmd_srch_q;
	logic        rx_shift_full_flag_q;
	logic        rbf_q;
	logic        rx_cmpl_q;
	logic        pd_q;
	logic        pdr_q;
	logic        reset_done;
	logic        start_byte;
	logic        conflict;
	logic        no_resp;
	logic        b2_val;
	logic        transfer;
	byte_t       status;

	// two flops on every input pin except RST before any logic looks at it
	always_ff @(posedge REF_CLK) begin
		sync1_q <= {ADDR, EN_N, RD_N, WR_N, DATA_IN, DQ_IN};
		sync2_q <= sync1_q;
	end

	assign {addr_s, en_n_s, rd_n_s, wr_n_s, din_s, dq_s} = sync2_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rd_n_prev_q <= 1'b1;
			wr_n_prev_q <= 1'b1;
			en_n_prev_q <= 1'b1;
		end else begin
			rd_n_prev_q <= rd_n_s;
			wr_n_prev_q <= wr_n_s;
			en_n_prev_q <= en_n_s;
		end
	end

	// write wins when both strobes are low
	assign wr_evt    = wr_n_prev_q & ~wr_n_s & ~en_n_s;
	assign rd_active = ~rd_n_s & wr_n_s & ~en_n_s;
	// read side effects land at the end of the strobe, after the data
	assign rd_end    = ~rd_n_prev_q & rd_n_s & wr_n_s & ~en_n_prev_q;

	assign tx_in.data  = din_s;
	assign tx_in.valid = wr_evt && (addr_s == `ADDR_DATA);

	byte_buffer #(
		.WIDTH (`BYTE_W),
		.DEPTH (`BUF_DEPTH)
	) u_tx_buf (
		.clk   (REF_CLK),
		.rst   (RST),
		.in_s  (tx_in),
		.out_s (tx_out)
	);

	bit_slot_engine u_slots (
		.clk   (REF_CLK),
		.rst   (RST),
		.dq_in (dq_s),
		.sl    (slot),
		.dq_oe (DQ_OE)
	);

	always_ff @(posedge REF_CLK) begin
		DQ_OUT <= 1'b0;
	end

	// a new byte waits until the shift register is free again
	assign start_byte = (state_q == ST_IDLE) && !cmd_rst_q &&
		!rx_shift_full_flag_q && tx_out.valid;
	assign tx_out.ready = start_byte;
	assign reset_done = (state_q == ST_RESET) && slot.done;
	assign transfer   = rx_cmpl_q && !rbf_q;

	// two zeros: conflict; both ones: nobody answered
	assign conflict = ~b0_q & ~slot.rbit;
	assign no_resp  = b0_q & slot.rbit;
	assign b2_val   = (err_q || no_resp) ? 1'b1 :
		conflict ? tx_sh_q[1] : b0_q;

	// command register
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cmd_rst_q  <= 1'b0;
			cmd_srch_q <= 1'b0;
		end else if (wr_evt && addr_s == `ADDR_CMD) begin
			// a running reset cannot be cancelled by software
			cmd_rst_q <= din_s[`CMD_RST_BIT] |
				(cmd_rst_q & ~reset_done);
			cmd_srch_q <= din_s[`CMD_SRCH_BIT] &
				~din_s[`CMD_RST_BIT] & ~cmd_rst_q;
		end else if (reset_done) begin
			cmd_rst_q <= 1'b0;
		end
	end

	// sticky search error, dropped only when search mode is left
	always_ff @(posedge REF_CLK) begin
		if (RST || !cmd_srch_q) begin
			err_q <= 1'b0;
		end else if (state_q == ST_SB1 && slot.done && no_resp) begin
			err_q <= 1'b1;
		end
	end

	// sequencer
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_q       <= ST_IDLE;
			tx_sh_q       <= 8'h00;
			rx_sh_q       <= 8'h00;
			bit_cnt_q     <= 3'h0;
			pos_cnt_q     <= 2'h0;
			b0_q          <= 1'b1;
			b2_q          <= 1'b1;
			disc_q        <= 1'b0;
			slot.req      <= 1'b0;
			slot.is_reset <= 1'b0;
			slot.wbit     <= 1'b1;
		end else begin
			slot.req <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (cmd_rst_q) begin
						slot.req      <= 1'b1;
						slot.is_reset <= 1'b1;
						state_q       <= ST_RESET;
					end else if (start_byte) begin
						tx_sh_q       <= tx_out.data;
						bit_cnt_q     <= 3'h0;
						pos_cnt_q     <= 2'h0;
						slot.req      <= 1'b1;
						slot.is_reset <= 1'b0;
						if (cmd_srch_q) begin
							slot.wbit <= 1'b1;
							state_q   <= ST_SB0;
						end else begin
							slot.wbit <= tx_out.data[0];
							state_q   <= ST_BYTE;
						end
					end
				end
				ST_RESET: begin
					if (slot.done) begin
						state_q <= ST_IDLE;
					end
				end
				ST_BYTE: begin
					if (slot.done) begin
						rx_sh_q   <= {slot.rbit, rx_sh_q[7:1]};
						tx_sh_q   <= {1'b1, tx_sh_q[7:1]};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == `LAST_BIT) begin
							state_q <= ST_IDLE;
						end else begin
							slot.req  <= 1'b1;
							slot.wbit <= tx_sh_q[1];
						end
					end
				end
				ST_SB0: begin
					if (slot.done) begin
						b0_q      <= slot.rbit;
						slot.req  <= 1'b1;
						slot.wbit <= 1'b1;
						state_q   <= ST_SB1;
					end
				end
				ST_SB1: begin
					if (slot.done) begin
						b2_q      <= b2_val;
						disc_q    <= conflict | no_resp;
						slot.req  <= 1'b1;
						slot.wbit <= b2_val;
						state_q   <= ST_SB2;
					end
				end
				ST_SB2: begin
					if (slot.done) begin
						// path in the odd bit, discrepancy in the even bit
						rx_sh_q   <= {b2_q, disc_q, rx_sh_q[7:2]};
						tx_sh_q   <= {2'h3, tx_sh_q[7:2]};
						pos_cnt_q <= pos_cnt_q + 2'h1;
						if (pos_cnt_q == `LAST_POS) begin
							state_q <= ST_IDLE;
						end else begin
							slot.req  <= 1'b1;
							slot.wbit <= 1'b1;
							state_q   <= ST_SB0;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// receive shift register flags
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rx_shift_full_flag_q    <= 1'b0;
			rx_cmpl_q <= 1'b0;
		end else begin
			if (start_byte) begin
				rx_shift_full_flag_q <= 1'b1;
			end else if (transfer) begin
				rx_shift_full_flag_q <= 1'b0;
			end
			if (transfer) begin
				rx_cmpl_q <= 1'b0;
			end else if (slot.done &&
				((state_q == ST_BYTE && bit_cnt_q == `LAST_BIT) ||
				(state_q == ST_SB2 && pos_cnt_q == `LAST_POS))) begin
				rx_cmpl_q <= 1'b1;
			end
		end
	end

	// receive buffer; host read clears full, a new move sets it
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rx_buf_q <= 8'h00;
			rbf_q    <= 1'b0;
		end else if (transfer) begin
			rx_buf_q <= rx_sh_q;
			rbf_q    <= 1'b1;
		end else if (rd_end && addr_s == `ADDR_DATA) begin
			rbf_q <= 1'b0;
		end
	end

	// presence flags; the set beats a status read in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pd_q  <= 1'b0;
			pdr_q <= `PDR_RESET;
		end else if (reset_done) begin
			pd_q  <= 1'b1;
			pdr_q <= ~slot.presence;
		end else if (rd_end && addr_s == `ADDR_STAT) begin
			pd_q  <= 1'b0;
			pdr_q <= 1'b0;
		end
	end

	always_comb begin
		status               = 8'h00;
		status[`ST_PD_BIT]   = pd_q;
		status[`ST_PDR_BIT]  = pdr_q;
		status[`ST_TBE_BIT]  = ~tx_out.valid;
		status[`ST_TEMT_BIT] = (state_q == ST_IDLE);
		status[`ST_RBF_BIT]  = rbf_q;
		status[`ST_RX_SHIFT_FULL_FLAG_BIT] = rx_shift_full_flag_q;
	end

	// host read data, registered
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			DATA_OUT <= 8'h00;
			DATA_OE  <= 1'b0;
		end else begin
			DATA_OE <= rd_active;
			case (addr_s)
				`ADDR_CMD: begin
					DATA_OUT <= {6'h00, cmd_srch_q, cmd_rst_q};
				end
				`ADDR_DATA: begin
					DATA_OUT <= rx_buf_q;
				end
				`ADDR_STAT: begin
					DATA_OUT <= status;
				end
				default: begin
					DATA_OUT <= 8'h00;
				end
			endcase
		end
	end
endmodule : single_wire_master_read_search

// *** single_wire_master_read_search_asserts.sv ***
// pin level assertions for the single wire bus master
`timescale 1ns/100ps
module single_wire_master_read_search_asserts (
	input wire logic       REF_CLK,
	input wire logic       RST,
	input wire logic [2:0] ADDR,
	input wire logic       EN_N,
	input wire logic       RD_N,
	input wire logic       WR_N,
	input wire logic [7:0] DATA_OUT,
	input wire logic       DATA_OE,
	input wire logic       DQ_OUT,
	input wire logic       DQ_OE
);
	logic [13:0] hi_q;
	logic [13:0] lo_q;
	logic        long_q;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// run lengths saturate so a long idle never wraps
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			hi_q <= 14'h0;
			lo_q <= 14'h3fff;
			long_q <= 1'b0;
		end else if (DQ_OE) begin
			lo_q <= 14'h0;
			hi_q <= (lo_q != 14'h0) ? 14'h1 : hi_q + 14'(hi_q != 14'h3fff);
		end else begin
			lo_q <= lo_q + 14'(lo_q != 14'h3fff);
			if (lo_q == 14'h0)
				long_q <= hi_q >= 14'h2328;
		end
	end
	a_dq_open_drain: assert property (DQ_OUT == 1'b0)
		else $error("line output driven high");
	a_low_width: assert property ($fell(DQ_OE) |-> hi_q inside
		{[14'h12:14'h16], [14'h5da:14'h5de], [14'h270e:14'h2712]})
		else $error("line low time not a slot or reset figure");
	a_reset_release: assert property ($rose(DQ_OE) && long_q
		|-> lo_q >= 14'h2706)
		else $error("slot started before reset recovery ended");
	a_slot_period: assert property ($rose(DQ_OE) && !long_q
		|-> 15'(hi_q) + 15'(lo_q) >= 15'h640)
		else $error("slots closer than one slot time");
	a_read_answer: assert property (!EN_N && WR_N && $fell(RD_N)
		|-> ##[2:4] DATA_OE)
		else $error("read data not driven");
	a_read_release: assert property (RD_N [*6] |-> !DATA_OE)
		else $error("data bus driven without read");
	a_write_quiet: assert property (!WR_N [*5] |-> !DATA_OE)
		else $error("data bus driven during write");
	a_cmd_exclusive: assert property (DATA_OE && ADDR == 3'h0
		|-> DATA_OUT[1:0] != 2'b11 && DATA_OUT[7:2] == 6'h0)
		else $error("command bits both set");
endmodule : single_wire_master_read_search_asserts

bind single_wire_master_read_search single_wire_master_read_search_asserts
	u_chk (
	.REF_CLK  (REF_CLK),
	.RST      (RST),
	.ADDR     (ADDR),
	.EN_N     (EN_N),
	.RD_N     (RD_N),
	.WR_N     (WR_N),
	.DATA_OUT (DATA_OUT),
	.DATA_OE  (DATA_OE),
	.DQ_OUT   (DQ_OUT),
	.DQ_OE    (DQ_OE)
);

// *** single_wire_master_read_search_tb_top.sv ***
// register level tests of the bus master against the slave model
`timescale 1ns/100ps
`include "swm_defines.svh"
module single_wire_master_read_search_tb_top
	import swm_pkg::*;
;
	logic        REF_CLK;
	logic        RST;
	logic        EN_N;
	logic        RD_N;
	logic        WR_N;
	logic [2:0]  ADDR;
	byte_t       DATA_IN;
	byte_t       DATA_OUT;
	logic        DATA_OE;
	logic        DQ_OUT;
	logic        DQ_OE;
	logic        dq;
	logic [31:0] seen;
	byte_t       rd;
	int          err_total = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          i;

	single_wire_master_read_search dut (
		.REF_CLK  (REF_CLK),
		.RST      (RST),
		.ADDR     (ADDR),
		.EN_N     (EN_N),
		.RD_N     (RD_N),
		.WR_N     (WR_N),
		.DATA_IN  (DATA_IN),
		.DATA_OUT (DATA_OUT),
		.DATA_OE  (DATA_OE),
		.DQ_IN    (dq),
		.DQ_OUT   (DQ_OUT),
		.DQ_OE    (DQ_OE)
	);
	// slots 0-15 answer two bytes, 16-27 four search positions
	swm_slave_model u_slave (
		.DQ_OE (DQ_OE),
		.pat   (32'hf9ec3ca5),
		.pres  (1'b1),
		.dq    (dq),
		.seen  (seen)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #25 REF_CLK = !REF_CLK;
	end

	task results();
		$display("checks %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	always @(posedge REF_CLK) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			err_total = err_total + 1;
			results();
		end
	end

	task check(input string name, input logic [31:0] got, exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// strobes stay low and high six clocks to clear the input syncs
	task wr(input logic [2:0] a, input byte_t d);
		@(posedge REF_CLK);
		ADDR <= a;
		DATA_IN <= d;
		EN_N <= 1'b0;
		WR_N <= 1'b0;
		repeat (6) @(posedge REF_CLK);
		WR_N <= 1'b1;
		repeat (6) @(posedge REF_CLK);
		EN_N <= 1'b1;
	endtask : wr

	task rd_reg(input logic [2:0] a, output byte_t d);
		int k;
		@(posedge REF_CLK);
		ADDR <= a;
		EN_N <= 1'b0;
		RD_N <= 1'b0;
		for (k = 0; k < 10 && DATA_OE !== 1'b1; k++)
			@(negedge REF_CLK);
		check("read answer", DATA_OE, 1'b1);
		d = DATA_OUT;
		@(posedge REF_CLK);
		RD_N <= 1'b1;
		repeat (6) @(posedge REF_CLK);
		EN_N <= 1'b1;
	endtask : rd_reg

	task wait_us(input int n);
		repeat (n * 20) @(posedge REF_CLK);
	endtask : wait_us

	initial begin
		RST = 1'b1;
		EN_N = 1'b1;
		RD_N = 1'b1;
		WR_N = 1'b1;
		ADDR = 3'h0;
		DATA_IN = 8'h00;
		repeat (4) @(posedge REF_CLK);
		RST <= 1'b0;
		rd_reg(`ADDR_STAT, rd);
		check("status reset", rd, 8'h0e);
		rd_reg(`ADDR_CMD, rd);
		check("cmd reset", rd, 8'h00);
		wr(`ADDR_CMD, 8'h02);
		rd_reg(`ADDR_CMD, rd);
		check("cmd search", rd, 8'h02);
		wr(`ADDR_CMD, 8'h01);
		rd_reg(`ADDR_CMD, rd);
		check("cmd reset wins", rd, 8'h01);
		for (i = 0; i < 15 && rd !== 8'h00; i++) begin
			wait_us(100);
			rd_reg(`ADDR_CMD, rd);
		end
		check("cmd self clear", rd, 8'h00);
		check("reset not early", i > 8, 1'b1);
		rd_reg(`ADDR_STAT, rd);
		check("presence", rd, 8'h0d);
		// second byte is the search command and queues behind the first
		wr(`ADDR_DATA, 8'hff);
		wr(`ADDR_DATA, 8'hf0);
		rd_reg(`ADDR_STAT, rd);
		check("shift full at start", rd & 8'h20, 8'h20);
		wait_us(1320);
		rd_reg(`ADDR_STAT, rd);
		// no further data write while both flags stand
		check("both full", rd & 8'h30, 8'h30);
		rd_reg(`ADDR_DATA, rd);
		check("byte one", rd, 8'ha5);
		rd_reg(`ADDR_STAT, rd);
		check("held byte moved", rd & 8'h30, 8'h10);
		rd_reg(`ADDR_DATA, rd);
		check("byte two", rd, 8'h30);
		rd_reg(`ADDR_STAT, rd);
		check("buffers empty", rd & 8'h30, 8'h00);
		check("wire order", seen[7:0], 8'ha5);
		check("wire and", seen[15:8], 8'h30);
		// positions: conflict, one, no answer, conflict after error
		wr(`ADDR_CMD, 8'h02);
		// first byte of a pass; the rest is cut to keep the run short
		wr(`ADDR_DATA, 8'h00);
		wait_us(1000);
		rd_reg(`ADDR_DATA, rd);
		check("search reply", rd, 8'hf9);
		check("written slots", {seen[27], seen[24], seen[21], seen[18]},
			4'b1110);
		wr(`ADDR_CMD, 8'h00);
		rd_reg(`ADDR_CMD, rd);
		check("cmd cleared", rd, 8'h00);
		results();
	end
endmodule : single_wire_master_read_search_tb_top

// *** swm_defines.svh ***
// constants for the single wire bus master read and search block
// Summary of operation
// - transmit write starts slot; capture wired-AND
// - full shift register moves to receive buffer
// - shift-full flag: set at start, cleared on move
// - buffer-full flag: set on move, cleared on read
// - completed byte waits while receive buffer full
// - command bit0 bus reset, bit1 search; one only
// - bus reset command pulses bus, clears search
// - bus reset bit self-clears when sequence ends
// - presence done set; result 0 means seen
// - odd bits direction, even don't-care, low first
// - per position: read, complement read, write slot
// - write value: direction, first read, or one
// - odd bits path, even bits discrepancy flag
// - reported path equals value driven in slot
// - after error path bits one until cleared
// - bits go out and in lsb first
// - offset one: write transmit, read receive buffer
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH
`define ADDR_CMD      3'h0
`define ADDR_DATA     3'h1
`define ADDR_STAT     3'h2
`define CMD_RST_BIT   0
`define CMD_SRCH_BIT  1
`define ST_PD_BIT     0
`define ST_PDR_BIT    1
`define ST_TBE_BIT    2
`define ST_TEMT_BIT   3
`define ST_RBF_BIT    4
`define ST_RX_SHIFT_FULL_FLAG_BIT   5
`define BYTE_W        8
`define BUF_DEPTH     2
`define PDR_RESET     1'h1
`define CLK_PERIOD_NS 16'h32
`define TAU_NS        16'h3e8
`define TAU_CYC       5'((`TAU_NS + `CLK_PERIOD_NS - 16'h1) / `CLK_PERIOD_NS)
`define T_RSTL_US     10'h1f4
`define T_RSTH_US     10'h1f4
`define T_PDH_MIN_US  10'h00f
`define T_PDH_MAX_US  10'h03c
`define T_PDS_US      10'h01e
`define T_SLOT_US     10'h050
`define T_LOW0_US     10'h04b
`define T_LOW1_US     10'h001
`define T_RDV_US      10'h00f
`define T_REC_US      10'h001
`define LAST_BIT      3'h7
`define LAST_POS      2'h3
`endif

// *** swm_ifs.sv ***
// byte stream and time slot carriers between the master's modules
`timescale 1ns/100ps
interface byte_stream_if;
	logic [7:0] data;
	logic       valid;
	logic       ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

interface slot_if;
	logic req;
	logic is_reset;
	logic wbit;
	logic done;
	logic rbit;
	logic presence;
	modport master (output req, output is_reset, output wbit,
		input done, input rbit, input presence);
	modport engine (input req, input is_reset, input wbit,
		output done, output rbit, output presence);
endinterface : slot_if

// *** swm_pkg.sv ***
// types shared by the bus master modules
package swm_pkg;
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_RESET = 6'b000010,
		ST_BYTE  = 6'b000100,
		ST_SB0   = 6'b001000,
		ST_SB1   = 6'b010000,
		ST_SB2   = 6'b100000
	} state_t;
	typedef logic [7:0] byte_t;
endpackage : swm_pkg

// *** swm_slave_model.sv ***
// behavioural slave on the open-drain line, answers from a bit pattern
`timescale 1ns/100ps
module swm_slave_model (
	input  wire logic        DQ_OE,
	input  wire logic [31:0] pat,
	input  wire logic        pres,
	output logic             dq,
	output logic [31:0]      seen
);
	logic pull;
	int   idx;
	time  t0;
	// pull-up: line high unless some party pulls it low
	assign dq = !(DQ_OE || pull);
	initial begin
		pull = 1'b0;
		idx = 0;
		seen = 32'h0;
	end
	// pull starts after the master's 1 us low, clear of its 15 us sample
	always begin
		@(negedge dq);
		t0 = $time;
		#2000 pull = !pat[idx];
		#28000 seen[idx] = dq;
		#15000 pull = 1'b0;
		wait (dq);
		if ($time - t0 > 400000) begin
			idx = 0;
			#20000 pull = pres;
			#100000 pull = 1'b0;
		end else begin
			idx = idx + 1;
		end
	end
endmodule : swm_slave_model
